// >>> design/uart_ctl_defs.vh
`ifndef UART_CTL_DEFS_VH
`define UART_CTL_DEFS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFS_CTRL1 8'h00
`define OFS_CTRL2 8'h04
`define OFS_STAT 8'h08
`define OFS_DATA 8'h0c
`define OFS_BAUD 8'h10
`define OFS_RXCNT 8'h14

// ----------------------------------------
// port_control_one fields
// ----------------------------------------
`define C1_EN 7
`define C1_BNO 6
`define C1_PREN 5
`define C1_PT_HI 4
`define C1_PT_LO 3
`define C1_BRK 2
`define C1_RX9 1
`define C1_TX9 0

// ----------------------------------------
// port_control_two fields
// ----------------------------------------
`define C2_TXEN 7
`define C2_RXEN 6
`define C2_STOP 5
`define C2_ADDR 4
`define C2_WAKE 3
`define C2_RIE 2
`define C2_TIIE 1
`define C2_TEIE 0

// ----------------------------------------
// reset values, encodings, counts
// ----------------------------------------
`define CTRL_RST 8'h00
`define BAUD_RST 16'h0010
`define PAR_EVEN 2'h0
`define PAR_ODD 2'h1
`define PAR_MARK 2'h2
`define PAR_SPACE 2'h3
`define BITS8 4'h8
`define BITS9 4'h9
`define BRK_BITS 4'hd

`endif

// >>> design/bit_timer.v
`include "uart_ctl_defs.vh"

// one bit-time counter: pulses at mid-bit and at bit end
module bit_timer (
	// clock and reset
	input wire i_clk,
	input wire i_rst,
	// control
	input wire i_run,
	input wire [15:0] i_div,
	// ticks
	output reg o_mid,
	output reg o_end
);

	reg [15:0] cnt_q;
	wire [15:0] last = i_div - 16'h0001;
	wire [15:0] half = {1'b0, i_div[15:1]};

	// ----------------------------------------
	// counter, restarted whenever run drops
	// ----------------------------------------
	// stopping clears the count so every frame starts on a full bit
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= 16'h0000;
			o_mid <= 1'b0;
			o_end <= 1'b0;
		end else if (!i_run) begin
			cnt_q <= 16'h0000;
			o_mid <= 1'b0;
			o_end <= 1'b0;
		end else begin
			o_mid <= (cnt_q == half);
			o_end <= (cnt_q >= last);
			if (cnt_q >= last)
				cnt_q <= 16'h0000;
			else
				cnt_q <= cnt_q + 16'h0001;
		end
	end

endmodule

// >>> design/uart_ctl.v
// The APB slave port and the register offsets were decided locally.
`include "uart_ctl_defs.vh"

// Functional notes
// R01: port disabled floats both line pins
// R02: disable empties buffer, restarts baud counter
// R03: disable clears enables and flags, sets idles
// R04: disable keeps other settings intact; the code also clears the break bit
// R05: disable aborts transfers in both directions
// R06: word length selects 8 or 9 bit frames
// R07: parity bit never stored as data
// R08: parity generated and checked only when enabled
// R09: parity type even odd mark space
// R10: break holds line low at least 13 bits
// R11: transmitter disable aborts, resets, floats pin
// R12: transmitter runs only when both enables set
// R13: receiver disable aborts, resets, floats pin
// R14: receiver runs only when both enables set
// R15: stop select gives one or two stops
// R16: address word with bit set raises request
// R17: data word with bit clear discarded silently
// R18: falling receive pin wakes when clock stopped
// R19: wake inactive with clock running or disabled
// R20: receive enable routes overrun and available
// R21: idle enable routes transmitter idle
// R22: empty enable routes transmit empty
// R23: transmitter enable sets transmit empty
// R24: request flag ORs enabled events, held
module uart_ctl (
	// clock and reset
	input wire I_CLK,
	input wire I_RST,
	// apb slave
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire I_PWRITE,
	input wire [7:0] I_PADDR,
	input wire [31:0] I_PWDATA,
	output reg [31:0] O_PRDATA,
	output reg O_PREADY,
	output reg O_PSLVERR,
	// transmit pin
	output reg O_TXD,
	output reg O_TXD_OE,
	// shared receive pin
	input wire I_RXD,
	output reg O_RXD,
	output reg O_RXD_OE,
	// wake-up and request
	input wire I_PCLK_OFF,
	output reg O_WAKE_REQ,
	input wire I_IRQ_ACK,
	output reg O_IRQ
);

	localparam T_IDLE = 3'h0;
	localparam T_START = 3'h1;
	localparam T_DATA = 3'h2;
	localparam T_STOP = 3'h3;
	localparam T_BRK = 3'h4;
	localparam R_IDLE = 2'h0;
	localparam R_START = 2'h1;
	localparam R_DATA = 2'h2;
	localparam R_STOP = 2'h3;

	// control fields
	reg port_en_q, bno_q, pren_q, brk_q, tx9_q, rx9_q;
	reg [1:0] ptype_q;
	reg tx_en_q, rx_en_q, stop2_q, addr_en_q, wake_en_q, rie_q, tiie_q, teie_q;
	reg [15:0] baud_q;
	// status flags and buffers
	reg tx_empty_q, tx_idle_q, rx_idle_q, rx_avail_q, ovr_q, ferr_q, perr_q;
	reg [7:0] tx_buf_q, rx_buf_q;
	// transmitter
	reg [2:0] tx_st_q;
	reg [8:0] tx_sh_q;
	reg [3:0] tx_cnt_q;
	// receiver
	reg [1:0] rx_st_q;
	reg [8:0] rx_sh_q;
	reg [3:0] rx_cnt_q;
	reg rx_in_q, rx_prev_q, rx_done_q, rx_stop_ok_q;
	// request edge history
	reg [3:0] ev_prev_q;

	wire tx_mid, tx_end, rx_mid, rx_end;

	// ----------------------------------------
	// parity helper
	// ----------------------------------------
	function par_bit;
		input [1:0] typ;
		input ones;
		begin
			case (typ) // see R09
			`PAR_EVEN: par_bit = ones;
			`PAR_ODD: par_bit = ~ones;
			`PAR_MARK: par_bit = 1'b1;
			default: par_bit = 1'b0;
			endcase
		end
	endfunction

	// ----------------------------------------
	// common decodes
	// ----------------------------------------
	wire run_tx = port_en_q & tx_en_q; // see R12
	wire run_rx = port_en_q & rx_en_q; // see R14
	wire [3:0] nbits = bno_q ? `BITS9 : `BITS8; // see R06
	wire acc = I_PSEL & I_PENABLE & O_PREADY;
	wire wr = acc & I_PWRITE;
	wire rd = acc & ~I_PWRITE;
	wire wr_c1 = wr & (I_PADDR == `OFS_CTRL1);
	wire wr_c2 = wr & (I_PADDR == `OFS_CTRL2);
	wire wr_dat = wr & (I_PADDR == `OFS_DATA);
	wire rd_dat = rd & (I_PADDR == `OFS_DATA);
	wire tx_load = run_tx & (tx_st_q == T_IDLE) & ~tx_empty_q & ~brk_q;

	// transmit frame, parity replacing the last bit
	wire tx_src = bno_q ? ^tx_buf_q : ^tx_buf_q[6:0];
	wire tx_par = par_bit(ptype_q, tx_src);
	wire [8:0] tx_frame = pren_q ? (bno_q ? {tx_par, tx_buf_q} // see R07
		: {1'b0, tx_par, tx_buf_q[6:0]}) // see R08
		: (bno_q ? {tx9_q, tx_buf_q} : {1'b0, tx_buf_q});

	// received word, aligned to bit 0
	wire [8:0] rx_word = bno_q ? rx_sh_q : {1'b0, rx_sh_q[8:1]};
	wire rx_src = bno_q ? ^rx_word[7:0] : ^rx_word[6:0];
	wire rx_par = bno_q ? rx_word[8] : rx_word[7];
	wire addr_bit = bno_q ? rx_word[8] : rx_word[7];
	wire rx_drop = addr_en_q & ~addr_bit; // see R17
	wire rx_perr = pren_q & (rx_par != par_bit(ptype_q, rx_src));

	// ----------------------------------------
	// baud timers, one per direction
	// ----------------------------------------
	// disabling stops both timers, which resets their counts
	bit_timer u_tx_timer (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_run(run_tx & (tx_st_q != T_IDLE)), // see R02
		.i_div(baud_q),
		.o_mid(tx_mid),
		.o_end(tx_end)
	);

	bit_timer u_rx_timer (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.i_run(run_rx & (rx_st_q != R_IDLE)),
		.i_div(baud_q),
		.o_mid(rx_mid),
		.o_end(rx_end)
	);

	// ----------------------------------------
	// apb answer: one wait state per access
	// ----------------------------------------
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
		end else if (I_PSEL & I_PENABLE & ~O_PREADY) begin
			O_PREADY <= 1'b1;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
			case (I_PADDR)
			`OFS_CTRL1: O_PRDATA[7:0] <= {port_en_q, bno_q, pren_q, ptype_q, brk_q,
				rx9_q, 1'b0}; // write-only ninth bit reads zero
			`OFS_CTRL2: O_PRDATA[7:0] <= {tx_en_q, rx_en_q, stop2_q, addr_en_q,
				wake_en_q, rie_q, tiie_q, teie_q};
			`OFS_STAT: O_PRDATA[7:0] <= {perr_q, 1'b0, ferr_q, ovr_q, rx_idle_q,
				rx_avail_q, tx_idle_q, tx_empty_q};
			`OFS_DATA: O_PRDATA[7:0] <= rx_buf_q;
			`OFS_BAUD: O_PRDATA[15:0] <= baud_q;
			`OFS_RXCNT: O_PRDATA[0] <= rx_avail_q;
			default: O_PSLVERR <= 1'b1;
			endcase
		end else begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	// disable clears the transmit and receive enables and the break bit; the rest survives re-enable
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{port_en_q, bno_q, pren_q, ptype_q, brk_q, tx9_q} <= 7'h00;
			{tx_en_q, rx_en_q, stop2_q, addr_en_q} <= 4'h0;
			{wake_en_q, rie_q, tiie_q, teie_q} <= 4'h0;
			baud_q <= `BAUD_RST;
		end else begin
			if (!port_en_q) begin
				tx_en_q <= 1'b0; // see R03
				rx_en_q <= 1'b0;
				brk_q <= 1'b0; // see R04
			end
			if (wr_c1) begin
				port_en_q <= I_PWDATA[`C1_EN];
				bno_q <= I_PWDATA[`C1_BNO];
				pren_q <= I_PWDATA[`C1_PREN];
				ptype_q <= I_PWDATA[`C1_PT_HI:`C1_PT_LO];
				brk_q <= I_PWDATA[`C1_BRK];
				tx9_q <= I_PWDATA[`C1_TX9];
			end
			if (wr_c2) begin
				tx_en_q <= I_PWDATA[`C2_TXEN];
				rx_en_q <= I_PWDATA[`C2_RXEN];
				stop2_q <= I_PWDATA[`C2_STOP];
				addr_en_q <= I_PWDATA[`C2_ADDR];
				wake_en_q <= I_PWDATA[`C2_WAKE];
				rie_q <= I_PWDATA[`C2_RIE];
				tiie_q <= I_PWDATA[`C2_TIIE];
				teie_q <= I_PWDATA[`C2_TEIE];
			end
			if (wr & (I_PADDR == `OFS_BAUD))
				baud_q <= I_PWDATA[15:0];
		end
	end

	// ----------------------------------------
	// buffers and status flags
	// ----------------------------------------
	// a frame landing on a data read is kept: the set beats the clear
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			{tx_empty_q, tx_idle_q, rx_idle_q} <= 3'h7;
			{rx_avail_q, ovr_q, ferr_q, perr_q} <= 4'h0;
			tx_buf_q <= 8'h00;
			rx_buf_q <= 8'h00;
			rx9_q <= 1'b0;
		end else if (!port_en_q) begin
			tx_empty_q <= 1'b1; // see R03
			tx_idle_q <= 1'b1;
			rx_idle_q <= 1'b1;
			{rx_avail_q, ovr_q, ferr_q, perr_q} <= 4'h0; // see R02
		end else begin
			// transmit side
			if (!run_tx | (wr_c2 & I_PWDATA[`C2_TXEN] & ~tx_en_q))
				tx_empty_q <= 1'b1; // see R11 R23
			else if (wr_dat)
				tx_empty_q <= 1'b0;
			else if (tx_load)
				tx_empty_q <= 1'b1;
			if (wr_dat)
				tx_buf_q <= I_PWDATA[7:0];
			tx_idle_q <= tx_empty_q & ~wr_dat & (tx_st_q == T_IDLE) & ~brk_q;
			// receive side
			rx_idle_q <= (rx_st_q == R_IDLE);
			if (!run_rx) begin
				{rx_avail_q, ovr_q, ferr_q, perr_q} <= 4'h0; // see R13
			end else if (rx_done_q & ~rx_drop) begin // see R16
				if (rx_avail_q & ~rd_dat) begin
					ovr_q <= 1'b1;
				end else begin
					rx_avail_q <= 1'b1;
					ovr_q <= 1'b0;
					ferr_q <= ~rx_stop_ok_q;
					perr_q <= rx_perr;
					rx_buf_q <= (pren_q & ~bno_q) ? {1'b0, rx_word[6:0]} : rx_word[7:0];
					if (bno_q & ~pren_q)
						rx9_q <= rx_word[8]; // see R07
				end
			end else if (rd_dat) begin
				{rx_avail_q, ovr_q, ferr_q, perr_q} <= 4'h0;
			end
		end
	end

	// ----------------------------------------
	// transmitter sequencer
	// ----------------------------------------
	// the pin is released at once when either enable drops
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			tx_st_q <= T_IDLE;
			tx_sh_q <= 9'h000;
			tx_cnt_q <= 4'h0;
			O_TXD <= 1'b1;
			O_TXD_OE <= 1'b0;
		end else if (!run_tx) begin
			tx_st_q <= T_IDLE; // see R05 R11
			tx_cnt_q <= 4'h0;
			O_TXD <= 1'b1;
			O_TXD_OE <= 1'b0; // see R01
		end else begin
			O_TXD_OE <= 1'b1;
			case (tx_st_q)
			T_IDLE: begin
				tx_cnt_q <= 4'h0;
				if (brk_q & tx_empty_q) begin
					tx_st_q <= T_BRK; // see R10
					O_TXD <= 1'b0;
				end else if (tx_load) begin
					tx_sh_q <= tx_frame;
					tx_st_q <= T_START;
					O_TXD <= 1'b0;
				end else begin
					O_TXD <= 1'b1;
				end
			end
			T_START: if (tx_end) begin
				O_TXD <= tx_sh_q[0];
				tx_sh_q <= {1'b0, tx_sh_q[8:1]};
				tx_cnt_q <= 4'h1;
				tx_st_q <= T_DATA;
			end
			T_DATA: if (tx_end) begin
				if (tx_cnt_q == nbits) begin
					O_TXD <= 1'b1;
					tx_cnt_q <= 4'h1;
					tx_st_q <= T_STOP;
				end else begin
					O_TXD <= tx_sh_q[0];
					tx_sh_q <= {1'b0, tx_sh_q[8:1]};
					tx_cnt_q <= tx_cnt_q + 4'h1;
				end
			end
			T_STOP: if (tx_end) begin
				if (stop2_q & (tx_cnt_q == 4'h1)) // see R15
					tx_cnt_q <= 4'h2;
				else
					tx_st_q <= T_IDLE;
			end
			T_BRK: begin
				O_TXD <= 1'b0;
				if (tx_end & (tx_cnt_q != `BRK_BITS))
					tx_cnt_q <= tx_cnt_q + 4'h1;
				if ((tx_cnt_q == `BRK_BITS) & ~brk_q) begin // see R10
					O_TXD <= 1'b1;
					tx_cnt_q <= 4'h2;
					tx_st_q <= T_STOP;
				end
			end
			default: tx_st_q <= T_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// receiver sequencer
	// ----------------------------------------
	// one sample per bit at mid-point; no majority vote, so no noise flag
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rx_st_q <= R_IDLE;
			rx_sh_q <= 9'h000;
			rx_cnt_q <= 4'h0;
			rx_in_q <= 1'b1;
			rx_prev_q <= 1'b1;
			rx_done_q <= 1'b0;
			rx_stop_ok_q <= 1'b0;
		end else begin
			rx_in_q <= I_RXD;
			rx_prev_q <= rx_in_q;
			rx_done_q <= 1'b0;
			if (!run_rx) begin
				rx_st_q <= R_IDLE; // see R05 R13
				rx_cnt_q <= 4'h0;
			end else begin
				case (rx_st_q)
				R_IDLE: if (rx_prev_q & ~rx_in_q)
					rx_st_q <= R_START;
				R_START: if (rx_mid) begin
					rx_cnt_q <= 4'h0;
					rx_st_q <= rx_in_q ? R_IDLE : R_DATA;
				end
				R_DATA: if (rx_mid) begin
					rx_sh_q <= {rx_in_q, rx_sh_q[8:1]};
					rx_cnt_q <= rx_cnt_q + 4'h1;
					if (rx_cnt_q == nbits - 4'h1)
						rx_st_q <= R_STOP;
				end
				R_STOP: if (rx_mid) begin
					rx_stop_ok_q <= rx_in_q;
					rx_done_q <= 1'b1;
					rx_st_q <= R_IDLE;
				end
				default: rx_st_q <= R_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// shared pin, wake-up and request flag
	// ----------------------------------------
	// the shared pin is receive-only here, so it is never driven
	always @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RXD <= 1'b1;
			O_RXD_OE <= 1'b0;
			O_WAKE_REQ <= 1'b0;
			O_IRQ <= 1'b0;
			ev_prev_q <= 4'h3; // idle and empty flags reset high, so no false edge
		end else begin
			O_RXD <= 1'b1;
			O_RXD_OE <= 1'b0; // see R01
			ev_prev_q <= {rx_avail_q, ovr_q, tx_idle_q, tx_empty_q};
			if (~I_PCLK_OFF | ~wake_en_q)
				O_WAKE_REQ <= 1'b0; // see R19
			else if (rx_prev_q & ~rx_in_q)
				O_WAKE_REQ <= 1'b1; // see R18
			if ((rie_q & ((rx_avail_q & ~ev_prev_q[3]) | (ovr_q & ~ev_prev_q[2]))) // see R20
				| (tiie_q & tx_idle_q & ~ev_prev_q[1]) // see R21
				| (teie_q & tx_empty_q & ~ev_prev_q[0]) // see R22
				| (wake_en_q & I_PCLK_OFF & rx_prev_q & ~rx_in_q))
				O_IRQ <= 1'b1; // see R24
			else if (I_IRQ_ACK)
				O_IRQ <= 1'b0;
		end
	end

endmodule

// >>> bench/uart_ctl_chk.sv
// ----------------------------------------
// port checker
// ----------------------------------------
module uart_ctl_chk (
	// clock and reset
	input wire I_CLK,
	input wire I_RST,
	// apb
	input wire I_PSEL,
	input wire I_PENABLE,
	input wire [31:0] O_PRDATA,
	input wire O_PREADY,
	input wire O_PSLVERR,
	// pins and requests
	input wire O_RXD_OE,
	input wire I_PCLK_OFF,
	input wire O_WAKE_REQ,
	input wire I_IRQ_ACK,
	input wire O_IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	// first access cycle, then a one-cycle answer
	sequence s_access;
		I_PSEL && I_PENABLE && !O_PREADY;
	endsequence
	sequence s_answer;
		O_PREADY ##1 !O_PREADY;
	endsequence
	a_ready_follows: assert property (s_access |=> s_answer)
		else $error("pready missing after access");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
		else $error("pslverr without pready");
	a_err_nodata: assert property (O_PSLVERR |-> O_PRDATA == 32'h0)
		else $error("refused read returned data");
	a_rdata_upper: assert property (O_PREADY |-> O_PRDATA[31:16] == 16'h0)
		else $error("read data upper half not zero");
	a_shared_float: assert property (!O_RXD_OE)
		else $error("shared pin driven");
	a_irq_held: assert property (O_IRQ && !I_IRQ_ACK |=> O_IRQ)
		else $error("request dropped without ack");
	a_wake_clock_on: assert property (!I_PCLK_OFF |=> !O_WAKE_REQ)
		else $error("wake request with clock running");
	a_wake_cause: assert property ($rose(O_WAKE_REQ) |-> $past(I_PCLK_OFF))
		else $error("wake request without clock off");
endmodule

// >>> bench/remote_line.sv
// ----------------------------------------
// far-end serial transceiver
// ----------------------------------------
module remote_line #(
	parameter int DIV = 4
) (
	input wire logic clk,
	input wire logic txd,
	output logic rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	// line rests at mark level
	initial rxd = 1'b1;
	task level(input logic v);
		@(posedge clk);
		rxd <= v;
	endtask
	// start, nb bits lsb first, then long stop
	task send(input logic [8:0] b, input int nb);
		int i;
		@(posedge clk);
		rxd <= 1'b0;
		repeat (DIV) @(posedge clk);
		for (i = 0; i < nb; i++) begin
			rxd <= b[i];
			repeat (DIV) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (3 * DIV) @(posedge clk);
	endtask
	// sample mid-bit; a missing start leaves the result wrong
	task recv(output logic [11:0] b, input int nb);
		int k;
		b = 12'h000;
		k = 0;
		while (txd !== 1'b0 && k < 2000) begin
			@(posedge clk);
			k++;
		end
		repeat (DIV / 2) @(posedge clk);
		for (k = 0; k < nb; k++) begin
			repeat (DIV) @(posedge clk);
			b[k] = txd;
		end
	endtask
endmodule

// >>> bench/testbench.sv
`include "uart_ctl_defs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 20;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, off = 0, ack = 0;
	logic [7:0] pa = 8'h00;
	logic [31:0] wd = 32'h0, rdat, prd;
	logic prdy, perr, txd, toe, rxd, rxo, rxoe, wk, irq, err, p;
	logic [11:0] f;
	logic [7:0] d;
	int num_errors = 0, tests_run = 0, n, t;
	always #2.5 clk = ~clk;
	uart_ctl u_uart_ctl(.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd), .O_PRDATA(prd), .O_PREADY(prdy),
		.O_PSLVERR(perr), .O_TXD(txd), .O_TXD_OE(toe), .I_RXD(rxd), .O_RXD(rxo),
		.O_RXD_OE(rxoe), .I_PCLK_OFF(off), .O_WAKE_REQ(wk), .I_IRQ_ACK(ack), .O_IRQ(irq));
	remote_line #(.DIV(DIV)) u_remote_line(.clk(clk), .txd(txd), .rxd(rxd));
	task wrap_up;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// apb master
	// ----------------------------------------
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pw <= w;
		pa <= a;
		wd <= v;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (prdy !== 1'b1 && k < 50);
		rdat = prd;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1) begin
			num_errors++;
			wrap_up();
		end
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK(rdat, e)
	endtask
	// one transmitted frame against the far end
	task frame(input logic [7:0] c1, input logic [7:0] dv, input int nb,
		input logic [11:0] e);
		xfer(1'b1, `OFS_CTRL1, {24'h0, c1});
		fork
			u_remote_line.recv(f, nb);
			xfer(1'b1, `OFS_DATA, {24'h0, dv});
		join
		`CHK(f, e)
	endtask
	task irq_ack;
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// reset values and a refused address
		rchk(`OFS_CTRL1, 32'h0);
		rchk(`OFS_CTRL2, 32'h0);
		rchk(`OFS_STAT, 32'h0b);
		rchk(`OFS_BAUD, 32'h10);
		xfer(1'b0, 8'h20, 32'h0);
		`CHK(err, 1'b1)
		xfer(1'b1, `OFS_BAUD, DIV);
		xfer(1'b1, `OFS_CTRL1, 32'h80);
		xfer(1'b1, `OFS_CTRL2, 32'hc5);
		// the pin enable follows the control write by one edge
		repeat (2) @(posedge clk);
		`CHK(toe, 1'b1)
		// every parity type, 9-bit words
		for (t = 0; t < 4; t++) begin
			d = 8'h35 + 8'h11 * t;
			case (t)
				0: p = ^d;
				1: p = ~^d;
				2: p = 1'b1;
				default: p = 1'b0;
			endcase
			frame(8'he0 | (t << 3), d, 10, {3'b001, p, d});
		end
		`CHK(irq, 1'b1)
		irq_ack();
		// no parity: ninth bit from store, two stops
		xfer(1'b1, `OFS_CTRL2, 32'he5);
		frame(8'hc1, 8'h5a, 11, {4'b0111, 8'h5a});
		xfer(1'b1, `OFS_CTRL1, 32'h80);
		irq_ack();
		// receive path and its request
		u_remote_line.send(9'h03c, 8);
		rchk(`OFS_RXCNT, 32'h1);
		rchk(`OFS_DATA, 32'h3c);
		`CHK(irq, 1'b1)
		irq_ack();
		// address filtering
		xfer(1'b1, `OFS_CTRL2, 32'hd5);
		u_remote_line.send(9'h012, 8);
		rchk(`OFS_RXCNT, 32'h0);
		`CHK(irq, 1'b0)
		u_remote_line.send(9'h093, 8);
		rchk(`OFS_RXCNT, 32'h1);
		`CHK(irq, 1'b1)
		rchk(`OFS_DATA, 32'h93);
		// break holds the line low past 13 bit times
		xfer(1'b1, `OFS_CTRL1, 32'h84);
		n = 0;
		while (txd !== 1'b0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		repeat (14 * DIV) begin
			@(posedge clk);
			if (txd === 1'b0)
				n++;
		end
		`CHK(n, 14 * DIV)
		xfer(1'b1, `OFS_CTRL1, 32'h80);
		repeat (4 * DIV) @(posedge clk);
		`CHK(txd, 1'b1)
		// a short break request still lasts 13 bit times
		xfer(1'b1, `OFS_CTRL1, 32'h84);
		n = 0;
		while (txd !== 1'b0 && n < 500) begin
			@(posedge clk);
			n++;
		end
		xfer(1'b1, `OFS_CTRL1, 32'h80);
		n = 0;
		while (txd === 1'b0 && n < 20 * DIV) begin
			@(posedge clk);
			n++;
		end
		// the count starts about four edges after the fall
		`CHK(n + 4 >= 13 * DIV && n < 14 * DIV, 1'b1)
		// an unread byte is thrown away by the disable
		u_remote_line.send(9'h0a5, 8);
		rchk(`OFS_RXCNT, 32'h1);
		// disable clears transmit and receive enables and flags, keeps settings
		xfer(1'b1, `OFS_CTRL1, 32'h0);
		rchk(`OFS_CTRL2, 32'h15);
		rchk(`OFS_STAT, 32'h0b);
		`CHK(toe, 1'b0)
		rchk(`OFS_BAUD, DIV);
		rchk(`OFS_RXCNT, 32'h0);
		// pin wake with the port clock stopped
		xfer(1'b1, `OFS_CTRL1, 32'h80);
		xfer(1'b1, `OFS_CTRL2, 32'h08);
		irq_ack();
		off <= 1'b1;
		u_remote_line.level(1'b0);
		n = 0;
		while (wk !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		`CHK(wk, 1'b1)
		`CHK(irq, 1'b1)
		off <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(wk, 1'b0)
		u_remote_line.level(1'b1);
		// transmitter disable mid-frame releases the pin at once
		xfer(1'b1, `OFS_CTRL2, 32'h80);
		xfer(1'b1, `OFS_DATA, 32'h0f);
		n = 0;
		while (txd !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		`CHK(txd, 1'b0)
		xfer(1'b1, `OFS_CTRL2, 32'h0);
		repeat (2) @(posedge clk);
		`CHK({toe, txd}, 2'b01)
		rchk(`OFS_STAT, 32'h0b);
		wrap_up();
	end
endmodule
bind uart_ctl uart_ctl_chk u_uart_ctl_chk(.I_CLK(I_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
	.O_PSLVERR(O_PSLVERR), .O_RXD_OE(O_RXD_OE), .I_PCLK_OFF(I_PCLK_OFF),
	.O_WAKE_REQ(O_WAKE_REQ), .I_IRQ_ACK(I_IRQ_ACK), .O_IRQ(O_IRQ));
